// ===== asrb_flag_alu.sv
// Instruction result and zero, digit-carry and carry flag logic
`timescale 1ns/1ns
`include "asrb_regs.svh"

module asrb_flag_alu (
	input  wire asrb_pkg::asrb_cmd_s cmd,      // Instruction and operands
	input  wire logic                carry_in, // Current carry flag
	output asrb_pkg::asrb_alu_s      alu       // Result and flag outputs
);

	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] addend;
	logic       cin;

	always_comb begin
		alu      = '0;
		addend   = cmd.w_val;
		cin      = 1'b0;
		// Subtraction adds the two's complement of the second operand
		if (cmd.op == asrb_pkg::OP_SUB) begin
			addend = ~cmd.w_val; // RULE_07
			cin    = 1'b1;
		end
		sum9 = {1'b0, cmd.file_val} + {1'b0, addend} + {8'h00, cin};
		sum5 = {1'b0, cmd.file_val[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
		unique case (cmd.op)
			asrb_pkg::OP_MOVE_FROM_W: alu.result = cmd.w_val;
			asrb_pkg::OP_CLEAR_FILE: begin
				alu.result   = 8'h00;
				alu.aff_zero = 1'b1;
			end
			asrb_pkg::OP_BIT_CLEAR: begin
				alu.result             = cmd.file_val;
				alu.result[cmd.bit_sel] = 1'b0;
			end
			asrb_pkg::OP_BIT_SET: begin
				alu.result             = cmd.file_val;
				alu.result[cmd.bit_sel] = 1'b1;
			end
			asrb_pkg::OP_NIBBLE_SWAP: alu.result = {cmd.file_val[3:0], cmd.file_val[7:4]};
			asrb_pkg::OP_ADD, asrb_pkg::OP_SUB: begin
				alu.result    = sum9[7:0];
				alu.carry     = sum9[8]; // RULE_12 RULE_06
				alu.digit     = sum5[4]; // RULE_12 RULE_06
				alu.aff_zero  = 1'b1;
				alu.aff_digit = 1'b1;
				alu.aff_carry = 1'b1;
			end
			asrb_pkg::OP_AND: begin
				alu.result   = cmd.file_val & cmd.w_val;
				alu.aff_zero = 1'b1;
			end
			asrb_pkg::OP_IOR: begin
				alu.result   = cmd.file_val | cmd.w_val;
				alu.aff_zero = 1'b1;
			end
			asrb_pkg::OP_XOR: begin
				alu.result   = cmd.file_val ^ cmd.w_val;
				alu.aff_zero = 1'b1;
			end
			asrb_pkg::OP_ROTATE_RIGHT: begin
				alu.result    = {carry_in, cmd.file_val[7:1]};
				alu.carry     = cmd.file_val[0]; // RULE_08
				alu.aff_carry = 1'b1;
			end
			asrb_pkg::OP_ROTATE_LEFT: begin
				alu.result    = {cmd.file_val[6:0], carry_in};
				alu.carry     = cmd.file_val[7]; // RULE_08
				alu.aff_carry = 1'b1;
			end
			default: alu.result = cmd.file_val;
		endcase
		alu.zero = (alu.result == 8'h00); // RULE_12
	end

endmodule

// ===== asrb_pkg.sv
// Types shared by the status bank modules
package asrb_pkg;

	// ------------------------------------------------------------
	// Instruction codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP          = 4'h0,
		OP_MOVE_FROM_W  = 4'h1,
		OP_CLEAR_FILE   = 4'h2,
		OP_BIT_CLEAR    = 4'h3,
		OP_BIT_SET      = 4'h4,
		OP_NIBBLE_SWAP  = 4'h5,
		OP_ADD          = 4'h6,
		OP_SUB          = 4'h7,
		OP_AND          = 4'h8,
		OP_IOR          = 4'h9,
		OP_XOR          = 4'hA,
		OP_ROTATE_RIGHT = 4'hB,
		OP_ROTATE_LEFT  = 4'hC,
		OP_WDT_CLEAR    = 4'hD,
		OP_SLEEP        = 4'hE
	} asrb_op_e;

	typedef struct packed {
		logic [7:0] w_val;
		logic [7:0] file_val;
		logic       dest_status;
		logic [2:0] bit_sel;
		asrb_op_e   op;
	} asrb_cmd_s;

	typedef struct packed {
		logic       aff_zero;
		logic       aff_digit;
		logic       aff_carry;
		logic       zero;
		logic       digit;
		logic       carry;
		logic [7:0] result;
	} asrb_alu_s;

endpackage

// ===== asrb_regs.svh
// Register offsets, field positions, reset values and clear-file masks for the status bank
`ifndef ASRB_REGS_SVH
`define ASRB_REGS_SVH

// ------------------------------------------------------------
// Register indices and byte addresses
// ------------------------------------------------------------
`define ASRB_ADDR_W          6
`define ASRB_IDX_STATUS      4'h3
`define ASRB_IDX_CMD         4'h4
`define ASRB_IDX_RESULT      4'h5
`define ASRB_IDX_EVENT       4'h6
`define ASRB_ADDR_STATUS     ({`ASRB_IDX_STATUS, 2'h0})
`define ASRB_ADDR_CMD        ({`ASRB_IDX_CMD, 2'h0})
`define ASRB_ADDR_RESULT     ({`ASRB_IDX_RESULT, 2'h0})
`define ASRB_ADDR_EVENT      ({`ASRB_IDX_EVENT, 2'h0})

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define ASRB_BIT_CARRY       0
`define ASRB_BIT_DIGIT       1
`define ASRB_BIT_ZERO        2
`define ASRB_BIT_PDOWN       3
`define ASRB_BIT_TOUT        4
`define ASRB_BIT_DBANK_LO    5
`define ASRB_BIT_DBANK_HI    6
`define ASRB_BIT_IBANK       7
`define ASRB_STATUS_RST      8'h18
`define ASRB_CLEAR_FILE_INSTR_KEEP       8'h1B
`define ASRB_CLEAR_FILE_INSTR_SET        8'h04

// ------------------------------------------------------------
// Command and event register fields
// ------------------------------------------------------------
`define ASRB_CMD_OP_MSB      3
`define ASRB_CMD_OP_LSB      0
`define ASRB_CMD_BIT_MSB     6
`define ASRB_CMD_BIT_LSB     4
`define ASRB_CMD_DEST        7
`define ASRB_CMD_FILE_MSB    15
`define ASRB_CMD_FILE_LSB    8
`define ASRB_CMD_W_MSB       23
`define ASRB_CMD_W_LSB       16
`define ASRB_EVT_WDT_TOUT    0

// ------------------------------------------------------------
// Bank decode
// ------------------------------------------------------------
`define ASRB_BANK_OFS_W      7
`define ASRB_DADDR_W         9

`endif

// ===== asrb_status_bank.sv
// ALU flags, reset cause and bank select register with an Avalon-MM slave
`timescale 1ns/1ns
`include "asrb_regs.svh"

// Summary of operation
// RULE_01: Status register writable like any data register.
// RULE_02: Flag instructions override written zero/digit/carry bits.
// RULE_03: Time-out and power-down bits ignore writes.
// RULE_04: Clear-file gives 000u u1uu pattern.
// RULE_05: Software should use bit/swap/move instructions.
// RULE_06: Carry and digit carry act as borrows.
// RULE_07: Subtract adds two's complement; set means none.
// RULE_08: Rotates load carry from low/high bit.
// RULE_09: Bank bits select direct and indirect banks.
// RULE_10: Time-out set on power-up/clear/sleep, cleared by timeout.
// RULE_11: Power-down set on power-up/clear, cleared by sleep.
// RULE_12: Zero, digit carry and carry from results.
module asrb_status_bank (
	input  wire logic                      core_clk,          // 10 MHz core clock
	input  wire logic                      reset,             // Synchronous power-on reset, high
	input  wire logic [`ASRB_ADDR_W-1:0]   avs_address,       // Byte address
	input  wire logic                      avs_read,          // Read request
	input  wire logic                      avs_write,         // Write request
	input  wire logic [31:0]               avs_writedata,     // Write data
	input  wire logic [3:0]                avs_byteenable,    // Byte lanes
	output logic      [31:0]               avs_readdata,      // Read data
	output logic                           avs_waitrequest,   // Stall until answer
	output logic                           indirect_bank_sel, // Indirect bank select
	output logic                           direct_bank_sel_hi,// Direct bank select high
	output logic                           direct_bank_sel_lo,// Direct bank select low
	output logic      [`ASRB_DADDR_W-1:0]  direct_bank_base,  // First address of direct bank
	output logic      [`ASRB_DADDR_W-1:0]  indirect_bank_base // First address of indirect bank
);

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK  = 2'b10
	} asrb_bus_e;

	asrb_bus_e           state;
	asrb_bus_e           next_state;
	logic                access;
	logic                wr_take;
	logic                rd_issue;

	assign access          = avs_read | avs_write;
	// Every access, mapped or not, answers one cycle after it appears
	assign avs_waitrequest = access & (state == ST_IDLE);
	assign wr_take         = avs_write & (state == ST_ACK);
	// Read data captured in the stall cycle so it leaves a flip-flop in the answer cycle
	assign rd_issue        = avs_read & (state == ST_IDLE);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: if (access) begin
				next_state = ST_ACK;
			end
			ST_ACK:  next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Byte lane merge
	// ------------------------------------------------------------
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [7:0]           status;
	logic [7:0]           next_status;
	asrb_pkg::asrb_cmd_s  cmd;
	asrb_pkg::asrb_cmd_s  next_cmd;
	logic [7:0]           result;
	logic [7:0]           next_result;
	logic [31:0]          next_readdata;
	logic [31:0]          cmd_merged;
	logic                 exec;
	logic                 status_wr;
	logic                 wdt_tout;
	asrb_pkg::asrb_cmd_s  exec_cmd;
	asrb_pkg::asrb_alu_s  alu;
	logic [7:0]           flag_mask;
	logic [7:0]           flag_val;
	logic [7:0]           keep_mask;

	assign exec      = wr_take & (avs_address == `ASRB_ADDR_CMD);
	assign status_wr = wr_take & (avs_address == `ASRB_ADDR_STATUS) & avs_byteenable[0];
	assign wdt_tout  = wr_take & (avs_address == `ASRB_ADDR_EVENT) & avs_byteenable[0]
		& avs_writedata[`ASRB_EVT_WDT_TOUT];

	// Instruction taken straight from the bus so it runs in the write's own cycle
	always_comb begin
		cmd_merged = lane_merge({8'h00, cmd}, avs_writedata, avs_byteenable);
		// Top lane has no command field
		exec_cmd   = asrb_pkg::asrb_cmd_s'(cmd_merged[23:0]);
		if (exec_cmd.dest_status) begin
			exec_cmd.file_val = status; // RULE_01
		end
	end

	asrb_flag_alu u_flag_alu (
		.cmd      (exec_cmd),
		.carry_in (status[`ASRB_BIT_CARRY]),
		.alu      (alu)
	);

	// ------------------------------------------------------------
	// Status update
	// ------------------------------------------------------------
	always_comb begin
		flag_mask = '0;
		flag_val  = '0;
		flag_mask[`ASRB_BIT_ZERO]  = alu.aff_zero;
		flag_mask[`ASRB_BIT_DIGIT] = alu.aff_digit;
		flag_mask[`ASRB_BIT_CARRY] = alu.aff_carry;
		flag_val[`ASRB_BIT_ZERO]   = alu.zero;
		flag_val[`ASRB_BIT_DIGIT]  = alu.digit;
		flag_val[`ASRB_BIT_CARRY]  = alu.carry;
		// Reset-cause bits are never taken from a written value
		keep_mask = '0;
		keep_mask[`ASRB_BIT_TOUT]  = 1'b1; // RULE_03
		keep_mask[`ASRB_BIT_PDOWN] = 1'b1; // RULE_03
		next_status = status;
		next_cmd    = cmd;
		next_result = result;
		if (status_wr) begin
			// Bus write behaves as a move into the register
			next_status = (status & keep_mask) | (avs_writedata[7:0] & ~keep_mask); // RULE_01 RULE_03
		end
		if (exec) begin
			next_cmd    = exec_cmd;
			next_result = alu.result;
			if (exec_cmd.dest_status && (exec_cmd.op != asrb_pkg::OP_WDT_CLEAR)
				&& (exec_cmd.op != asrb_pkg::OP_SLEEP) && (exec_cmd.op != asrb_pkg::OP_NOP)) begin
				if (flag_mask != 8'h00) begin
					// Flag-producing write: all three flag bits blocked from the result
					keep_mask[`ASRB_BIT_ZERO]  = 1'b1; // RULE_02
					keep_mask[`ASRB_BIT_DIGIT] = 1'b1; // RULE_02
					keep_mask[`ASRB_BIT_CARRY] = 1'b1; // RULE_02
				end
				next_status = (status & keep_mask) | (alu.result & ~keep_mask); // RULE_01
			end
			if (exec_cmd.op == asrb_pkg::OP_CLEAR_FILE && exec_cmd.dest_status) begin
				next_status = (status & `ASRB_CLEAR_FILE_INSTR_KEEP) | `ASRB_CLEAR_FILE_INSTR_SET; // RULE_04
			end else begin
				next_status = (next_status & ~flag_mask) | (flag_val & flag_mask); // RULE_02 RULE_12
			end
			unique case (exec_cmd.op)
				asrb_pkg::OP_WDT_CLEAR: begin
					next_status[`ASRB_BIT_TOUT]  = 1'b1; // RULE_10
					next_status[`ASRB_BIT_PDOWN] = 1'b1; // RULE_11
				end
				asrb_pkg::OP_SLEEP: begin
					next_status[`ASRB_BIT_TOUT]  = 1'b1; // RULE_10
					next_status[`ASRB_BIT_PDOWN] = 1'b0; // RULE_11
				end
				default: ;
			endcase
		end
		// Time-out event wins over a same-cycle instruction
		if (wdt_tout) begin
			next_status[`ASRB_BIT_TOUT] = 1'b0; // RULE_10
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		next_readdata = '0;
		if (rd_issue) begin
			unique case (avs_address)
				`ASRB_ADDR_STATUS: next_readdata = {24'h000000, status};
				`ASRB_ADDR_CMD:    next_readdata = {8'h00, cmd};
				`ASRB_ADDR_RESULT: next_readdata = {24'h000000, result};
				default:           next_readdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			status       <= `ASRB_STATUS_RST; // RULE_10 RULE_11
			cmd          <= '0;
			result       <= '0;
			avs_readdata <= '0;
		end else begin
			status       <= next_status;
			cmd          <= next_cmd;
			result       <= next_result;
			avs_readdata <= next_readdata;
		end
	end

	// ------------------------------------------------------------
	// Bank select outputs
	// ------------------------------------------------------------
	assign indirect_bank_sel  = status[`ASRB_BIT_IBANK];
	assign direct_bank_sel_hi = status[`ASRB_BIT_DBANK_HI];
	assign direct_bank_sel_lo = status[`ASRB_BIT_DBANK_LO];
	// Four 128-byte direct banks; indirect picks the lower or upper half
	assign direct_bank_base   = {status[`ASRB_BIT_DBANK_HI], status[`ASRB_BIT_DBANK_LO],
		{`ASRB_BANK_OFS_W{1'b0}}}; // RULE_09
	assign indirect_bank_base = {status[`ASRB_BIT_IBANK], {(`ASRB_DADDR_W-1){1'b0}}}; // RULE_09

endmodule

// ===== asrb_status_bank_assertions.sv
// Port checks for the status and bank select register
`timescale 1ns/1ns
`include "asrb_regs.svh"

module asrb_status_bank_assertions (
	input wire logic                     core_clk,           // Clock
	input wire logic                     reset,              // Reset
	input wire logic [`ASRB_ADDR_W-1:0]  avs_address,        // Address
	input wire logic                     avs_read,           // Read
	input wire logic                     avs_write,          // Write
	input wire logic [31:0]              avs_writedata,      // Write data
	input wire logic [3:0]               avs_byteenable,     // Lanes
	input wire logic [31:0]              avs_readdata,       // Read data
	input wire logic                     avs_waitrequest,    // Stall
	input wire logic                     indirect_bank_sel,  // Indirect bank
	input wire logic                     direct_bank_sel_hi, // Direct bank high
	input wire logic                     direct_bank_sel_lo, // Direct bank low
	input wire logic [`ASRB_DADDR_W-1:0] direct_bank_base,   // Direct base
	input wire logic [`ASRB_DADDR_W-1:0] indirect_bank_base  // Indirect base
);
	wire logic [2:0] bank = {indirect_bank_sel, direct_bank_sel_hi, direct_bank_sel_lo};
	wire logic       st_acc = avs_write && !avs_waitrequest && avs_address == `ASRB_ADDR_STATUS;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	dbase_map_a: assert property (direct_bank_base == {bank[1:0], 7'h00})
		else $error("direct bank base wrong");
	ibase_map_a: assert property (indirect_bank_base == {bank[2], 8'h00})
		else $error("indirect bank base wrong");
	wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("answer not one cycle after request");
	idle_free_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("stall without request");
	rdata_idle_a: assert property (!avs_read |-> avs_readdata == 32'h0)
		else $error("read data outside a read");
	bank_write_a: assert property (st_acc && avs_byteenable[0] |=> bank == $past(avs_writedata[7:5]))
		else $error("bank bits not written");
	lane_refuse_a: assert property (st_acc && !avs_byteenable[0] |=> $stable(bank))
		else $error("write without lane 0 took effect");
	bank_hold_a: assert property (!$past(avs_write) && !$past(reset) |-> $stable(bank))
		else $error("bank bits moved without a write");
endmodule

bind asrb_status_bank asrb_status_bank_assertions u_chk (
	.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .indirect_bank_sel(indirect_bank_sel),
	.direct_bank_sel_hi(direct_bank_sel_hi), .direct_bank_sel_lo(direct_bank_sel_lo),
	.direct_bank_base(direct_bank_base), .indirect_bank_base(indirect_bank_base)
);

// ===== tb_alu_status_bank_select_register.sv
// Self-checking bench for the status and bank select register
`timescale 1ns/1ns
`include "asrb_regs.svh"

module tb_alu_status_bank_select_register;
	typedef struct packed {
		logic [5:0]  a;
		logic [31:0] d;
		logic [3:0]  be;
		logic [7:0]  st;
		logic [8:0]  res; // Bit 8 set: result byte checked
	} asrb_row_s;

	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata, rdv;
	logic        avs_waitrequest, indirect_bank_sel, direct_bank_sel_hi, direct_bank_sel_lo;
	logic [8:0]  direct_bank_base, indirect_bank_base;
	int          err_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	asrb_row_s   rows [0:22];

	asrb_status_bank DUT (
		.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .indirect_bank_sel(indirect_bank_sel),
		.direct_bank_sel_hi(direct_bank_sel_hi), .direct_bank_sel_lo(direct_bank_sel_lo),
		.direct_bank_base(direct_bank_base), .indirect_bank_base(indirect_bank_base)
	);

	always #50 core_clk = ~core_clk;

	// Far above the few hundred cycles the sequence needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run;
		end
	end

	// Request held until the rising edge that sees the stall low; data taken at that edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge core_clk);
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= !wr;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		rdv = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_status(input logic [7:0] e);
		bus(1'b0, `ASRB_ADDR_STATUS, 32'h0, 4'hF);
		chk(rdv, {24'h0, e});
		chk({29'h0, indirect_bank_sel, direct_bank_sel_hi, direct_bank_sel_lo}, {29'h0, e[7:5]});
		chk({23'h0, direct_bank_base}, {23'h0, e[6:5], 7'h00});
		chk({23'h0, indirect_bank_base}, {23'h0, e[7], 8'h00});
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		rows = '{
			'{6'h0C, 32'h000000E7, 4'hF, 8'hFF, 9'h000},
			'{6'h0C, 32'h00000000, 4'hF, 8'h18, 9'h000},
			'{6'h0C, 32'h00000020, 4'hF, 8'h38, 9'h000},
			'{6'h0C, 32'h00000040, 4'hF, 8'h58, 9'h000},
			'{6'h0C, 32'h000000E3, 4'hF, 8'hFB, 9'h000},
			'{6'h10, 32'h00000082, 4'hF, 8'h1F, 9'h100},
			'{6'h18, 32'h00000001, 4'hF, 8'h0F, 9'h000},
			'{6'h10, 32'h0000000D, 4'hF, 8'h1F, 9'h000},
			'{6'h10, 32'h0000000E, 4'hF, 8'h17, 9'h000},
			'{6'h10, 32'h00010F06, 4'hF, 8'h12, 9'h110},
			'{6'h10, 32'h00011007, 4'hF, 8'h11, 9'h10F},
			'{6'h10, 32'h00020107, 4'hF, 8'h10, 9'h1FF},
			'{6'h10, 32'h00050507, 4'hF, 8'h17, 9'h100},
			'{6'h10, 32'h0000020B, 4'hF, 8'h16, 9'h181},
			'{6'h10, 32'h0000800C, 4'hF, 8'h17, 9'h100},
			'{6'h10, 32'h00200086, 4'hF, 8'h30, 9'h137},
			'{6'h10, 32'h00000085, 4'hF, 8'h13, 9'h103},
			'{6'h10, 32'h000000F4, 4'hF, 8'h93, 9'h000},
			'{6'h10, 32'h000000F3, 4'hF, 8'h13, 9'h000},
			'{6'h10, 32'h00000081, 4'hF, 8'h10, 9'h000},
			'{6'h10, 32'h000FF008, 4'hF, 8'h14, 9'h100},
			'{6'h10, 32'h000FF009, 4'hF, 8'h10, 9'h1FF},
			'{6'h10, 32'h003C3C0A, 4'hF, 8'h14, 9'h100}
		};
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		chk_status(8'h18);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d, rows[i].be);
			chk_status(rows[i].st);
			if (rows[i].res[8]) begin
				bus(1'b0, `ASRB_ADDR_RESULT, 32'h0, 4'hF);
				chk(rdv, {24'h0, rows[i].res[7:0]});
			end
		end
		// Awkward cases: missing lane, unmapped place, reset in mid-run
		bus(1'b1, `ASRB_ADDR_STATUS, 32'h000000FF, 4'hE);
		chk_status(8'h14);
		bus(1'b1, 6'h3C, 32'h000000FF, 4'hF);
		bus(1'b0, 6'h3C, 32'h0, 4'hF);
		chk(rdv, 32'h0);
		bus(1'b1, `ASRB_ADDR_STATUS, 32'h000000E0, 4'hF);
		@(posedge core_clk);
		reset <= 1'b1;
		@(posedge core_clk);
		reset <= 1'b0;
		chk_status(8'h18);
		complete_run;
	end
endmodule
